// [test/chsd_link_sva.sv]
/* Checker of the link between host socket end and card end.
   Assumes one clock and an active-high reset covering both ends. */
`timescale 1ns/1ps
module chsd_link_sva #(
    parameter int STROBE_CYCLES = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [10:0] addr,
    input wire logic attr_select_n,
    input wire logic card_enable_even_n,
    input wire logic card_enable_odd_n,
    input wire logic mem_rd_n,
    input wire logic mem_wr_n,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    input wire logic dev_status_oe,
    input wire logic dev_aux_oe,
    input wire logic host_status_o,
    input wire logic host_status_oe,
    input wire logic host_aux_o,
    input wire logic host_aux_oe,
    input wire logic status_pin,
    input wire logic aux_pin
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic idle;
    logic [7:0] low_cnt_r;
    assign idle = mem_rd_n & mem_wr_n & io_rd_n & io_wr_n;
    // Counts the cycles that a strobe has been low.
    always_ff @(posedge clk_sys_i) begin
        low_cnt_r <= idle ? 8'h00 : low_cnt_r + 8'h01;
    end
    property p_len; $rose(idle) |-> low_cnt_r == STROBE_CYCLES; endproperty
    a_len: assert property (p_len) else $error("strobe length wrong");
    property p_one; !idle |-> $onehot(~{mem_rd_n, mem_wr_n, io_rd_n, io_wr_n}); endproperty
    a_one: assert property (p_one) else $error("two strobes at once");
    property p_addr; !idle && !$past(idle) |-> $stable(addr) && $stable(attr_select_n); endproperty
    a_addr: assert property (p_addr) else $error("address moved in access");
    property p_sel; !idle && !$past(idle) |-> $stable({card_enable_even_n, card_enable_odd_n}); endproperty
    a_sel: assert property (p_sel) else $error("enables moved in access");
    property p_rel; idle |-> card_enable_even_n && card_enable_odd_n; endproperty
    a_rel: assert property (p_rel) else $error("enable low outside access");
    property p_diag; host_status_oe |-> !host_status_o; endproperty
    a_diag: assert property (p_diag) else $error("diag pin driven high");
    property p_act; host_aux_oe |-> !host_aux_o; endproperty
    a_act: assert property (p_act) else $error("active pin driven high");
    property p_boot; $past(rst_i) |-> !dev_status_oe && !dev_aux_oe && idle; endproperty
    a_boot: assert property (p_boot) else $error("pins driven after reset");
    c_acc: cover property ($rose(idle));
    c_alert: cover property ($fell(status_pin));
    c_aux: cover property ($fell(aux_pin));
endmodule : chsd_link_sva

// [test/testbench.sv]
/* Bench of host end and card end joined by the link.
   Assumes the package and the link interface are compiled first. */
`timescale 1ns/1ps
module testbench;
    import chsd_pkg::*;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
    logic clk_sys_i = 1'b0, rst_h = 1'b1, rst_c = 1'b1;
    always #2 clk_sys_i = ~clk_sys_i;
    int err_total = 0, cmp_count = 0, cyc = 0, n;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    chsd_mode_t mode_i = CHSD_MODE_MEM;
    logic io_configured_i = 1'b1, alert_enable_i = 1'b1, ready_busy_state_i = 1'b0, write_protect_i = 1'b0;
    logic alert_clear_i = 1'b0, diag_drive_i = 1'b0, active_drive_i = 1'b0;
    logic sel_valid_o, sel_write_o, lane_even_o, lane_odd_o, odd_on_low_o, data_drive_o, is_master_o;
    logic alert_pending_o, peer_diag_n_o, peer_active_n_o;
    chsd_region_t sel_region_o;
    logic [10:0] sel_index_o;
    logic [14:0] cap;
    int capn = 0;
    chsd_link_if lk();
    chsd_host_end #(.STROBE_CYCLES(2)) u_chsd_host_end (.*, .rst_i(rst_h), .link(lk));
    chsd_card_end u_chsd_card_end (.*, .rst_i(rst_c), .link(lk));
    chsd_link_sva #(.STROBE_CYCLES(2)) u_chsd_link_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_h | rst_c),
        .addr(lk.addr), .attr_select_n(lk.attr_select_n), .card_enable_even_n(lk.card_enable_even_n),
        .card_enable_odd_n(lk.card_enable_odd_n), .mem_rd_n(lk.mem_rd_n), .mem_wr_n(lk.mem_wr_n),
        .io_rd_n(lk.io_rd_n), .io_wr_n(lk.io_wr_n), .dev_status_oe(lk.dev_status_oe),
        .dev_aux_oe(lk.dev_aux_oe), .host_status_o(lk.host_status_o), .host_status_oe(lk.host_status_oe),
        .host_aux_o(lk.host_aux_o), .host_aux_oe(lk.host_aux_oe), .status_pin(lk.status_pin),
        .aux_pin(lk.aux_pin));
    // Keeps the last decoded select seen on the card side.
    always @(posedge clk_sys_i) begin
        if (sel_valid_o) begin
            cap <= {sel_region_o, sel_index_o[2:0], sel_write_o, data_drive_o, lane_even_o, lane_odd_o, odd_on_low_o};
            capn <= capn + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            final_report;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid | s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge clk_sys_i);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk_sys_i);
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic acc(input logic [15:0] w, input logic [14:0] e);
        wr(REG_ACCESS, {16'h0000, w});
        do rd(REG_STATUS); while (d[ST_BUSY_BIT]);
        `CHK(cap, e)
    endtask : acc
    task final_report;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_h <= 1'b0;
        rst_c <= 1'b0;
        rd(8'h14);
        `CHK({rsp, d}, {RESP_SLVERR, 32'h0})
        `CHK(is_master_o, 1'b0)
        rd(REG_STATUS);
        `CHK(d[2:1], 2'h3)
        acc(16'h1800, {CHSD_RGN_CIS, 3'h0, 2'h1, 3'h4});
        acc(16'h1A00, {CHSD_RGN_CONFIG, 3'h0, 2'h1, 3'h4});
        acc(16'h2001, {CHSD_RGN_MEM_REG, 3'h1, 2'h1, 3'h2});
        acc(16'h1001, {CHSD_RGN_MEM_REG, 3'h1, 2'h1, 3'h3});
        acc(16'hB003, {CHSD_RGN_MEM_REG, 3'h3, 2'h2, 3'h6});
        wr(REG_CTRL, 32'h2);
        mode_i <= CHSD_MODE_IO;
        acc(16'h5804, {CHSD_RGN_IO_PORT, 3'h4, 2'h1, 3'h4});
        wr(REG_IRQ_MASK, 32'h1);
        ready_busy_state_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        `CHK(irq_o, 1'b1)
        rd(REG_STATUS);
        `CHK(d[ST_AUX_PIN_BIT], 1'b1)
        alert_clear_i <= 1'b1;
        @(posedge clk_sys_i);
        alert_clear_i <= 1'b0;
        wr(REG_IRQ_STATUS, 32'h1);
        rd(REG_IRQ_STATUS);
        `CHK({irq_o, d[IRQ_ALERT_BIT]}, 2'h0)
        alert_enable_i <= 1'b0;
        write_protect_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rd(REG_IRQ_STATUS);
        `CHK(d[IRQ_ALERT_BIT], 1'b0)
        wr(REG_CTRL, 32'h3C);
        mode_i <= CHSD_MODE_DISK_INTERFACE;
        rst_c <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_c <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        `CHK({is_master_o, peer_diag_n_o, peer_active_n_o}, 3'h4)
        acc(16'hD004, {CHSD_RGN_TASKFILE, 3'h4, 2'h2, 3'h4});
        acc(16'h6006, {CHSD_RGN_CTRL_BLOCK, 3'h6, 2'h1, 3'h4});
        n = capn;
        wr(REG_ACCESS, 32'h4003);
        do rd(REG_STATUS); while (d[ST_BUSY_BIT]);
        `CHK(capn, n)
        wr(REG_CTRL, 32'h1C);
        active_drive_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd(REG_STATUS);
        `CHK(d[2:1], 2'h0)
        final_report;
    end
endmodule : testbench

// [verilog/chsd_card_end.sv]
/*
  Card end: decodes pin accesses into register selects and drives shared pins.
  Assumes pins synchronous to clk_sys_i and mode set by the card core.
*/
`timescale 1ns/1ps
module chsd_card_end (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    chsd_link_if.device link,
    input wire chsd_pkg::chsd_mode_t mode_i,
    input wire logic io_configured_i,
    input wire logic alert_enable_i,
    input wire logic ready_busy_state_i,
    input wire logic write_protect_i,
    input wire logic alert_clear_i,
    input wire logic diag_drive_i,
    input wire logic active_drive_i,
    output logic sel_valid_o,
    output chsd_pkg::chsd_region_t sel_region_o,
    output logic [chsd_pkg::ADDR_W-1:0] sel_index_o,
    output logic sel_write_o,
    output logic lane_even_o,
    output logic lane_odd_o,
    output logic odd_on_low_o,
    output logic data_drive_o,
    output logic is_master_o,
    output logic alert_pending_o,
    output logic peer_diag_n_o,
    output logic peer_active_n_o
);
    import chsd_pkg::*;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic mem_acc;
    logic io_acc;
    logic rd_acc;
    logic disk;
    chsd_region_t region_nxt;
    logic [ADDR_W-1:0] index_nxt;
    logic even_nxt;
    logic odd_nxt;
    logic swap_nxt;

    always_comb begin
        mem_acc = ~(link.mem_rd_n & link.mem_wr_n);
        io_acc = ~(link.io_rd_n & link.io_wr_n);
        rd_acc = ~(link.mem_rd_n & link.io_rd_n);
        disk = (mode_i == CHSD_MODE_DISK_INTERFACE);
        region_nxt = chsd_decode(mode_i, link.addr, link.attr_select_n, link.card_enable_even_n,
                                 link.card_enable_odd_n, mem_acc, io_acc);
        if (disk) begin
            index_nxt = {{(ADDR_W-IDE_ADDR_W){1'b0}}, link.addr[IDE_ADDR_W-1:0]};
            even_nxt = 1'b1;
            odd_nxt = 1'b0;
            swap_nxt = 1'b0;
        end else begin
            index_nxt = link.addr;
            even_nxt = ~link.card_enable_even_n & (~link.card_enable_odd_n | ~link.addr[0]);
            odd_nxt = ~link.card_enable_odd_n | (~link.card_enable_even_n & link.addr[0]);
            swap_nxt = ~link.card_enable_even_n & link.card_enable_odd_n & link.addr[0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sel_valid_o <= 1'b0;
            sel_region_o <= CHSD_RGN_NONE;
            sel_index_o <= '0;
            sel_write_o <= 1'b0;
            lane_even_o <= 1'b0;
            lane_odd_o <= 1'b0;
            odd_on_low_o <= 1'b0;
            data_drive_o <= 1'b0;
        end else begin
            sel_valid_o <= (region_nxt != CHSD_RGN_NONE);
            sel_region_o <= region_nxt;
            sel_index_o <= index_nxt;
            sel_write_o <= ~(link.mem_wr_n & link.io_wr_n);
            lane_even_o <= (region_nxt != CHSD_RGN_NONE) & even_nxt;
            lane_odd_o <= (region_nxt != CHSD_RGN_NONE) & odd_nxt;
            odd_on_low_o <= (region_nxt != CHSD_RGN_NONE) & swap_nxt;
            data_drive_o <= (region_nxt != CHSD_RGN_NONE) & rd_acc;
        end
    end

    // ------------------------------------------------------------
    // Status change alert
    // ------------------------------------------------------------
    logic rdy_prev_r;
    logic wp_prev_r;
    logic change_evt;

    assign change_evt = (ready_busy_state_i != rdy_prev_r) | (write_protect_i != wp_prev_r);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdy_prev_r <= 1'b0;
            wp_prev_r <= 1'b0;
            alert_pending_o <= 1'b0;
        end else begin
            rdy_prev_r <= ready_busy_state_i;
            wp_prev_r <= write_protect_i;
            // A change in the clearing cycle keeps the alert raised.
            alert_pending_o <= change_evt | (alert_pending_o & ~alert_clear_i);
        end
    end

    // ------------------------------------------------------------
    // Shared pin drive
    // ------------------------------------------------------------
    logic battery_level_one;
    logic battery_level_two;
    logic state_change_alert_n;
    logic audio_out_n;
    logic passed_diagnostic_n;
    logic active_slave_present_n;

    always_comb begin
        battery_level_one = 1'b1;
        battery_level_two = 1'b1;
        state_change_alert_n = ~(alert_pending_o & alert_enable_i & io_configured_i);
        audio_out_n = 1'b1;
        passed_diagnostic_n = ~diag_drive_i;
        active_slave_present_n = ~active_drive_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            link.dev_status_o <= 1'b1;
            link.dev_status_oe <= 1'b0;
            link.dev_aux_o <= 1'b1;
            link.dev_aux_oe <= 1'b0;
        end else begin
            unique case (mode_i)
                CHSD_MODE_MEM: begin
                    link.dev_status_o <= battery_level_one;
                    link.dev_status_oe <= 1'b1;
                    link.dev_aux_o <= battery_level_two;
                    link.dev_aux_oe <= 1'b1;
                end
                CHSD_MODE_IO: begin
                    link.dev_status_o <= state_change_alert_n;
                    link.dev_status_oe <= 1'b1;
                    link.dev_aux_o <= audio_out_n;
                    link.dev_aux_oe <= 1'b1;
                end
                CHSD_MODE_DISK_INTERFACE: begin
                    // Open drain so the peer drive can share both pins.
                    link.dev_status_o <= 1'b0;
                    link.dev_status_oe <= ~passed_diagnostic_n;
                    link.dev_aux_o <= 1'b0;
                    link.dev_aux_oe <= ~active_slave_present_n;
                end
                default: begin
                    link.dev_status_o <= 1'b1;
                    link.dev_status_oe <= 1'b0;
                    link.dev_aux_o <= 1'b1;
                    link.dev_aux_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            peer_diag_n_o <= 1'b1;
            peer_active_n_o <= 1'b1;
        end else begin
            peer_diag_n_o <= (mode_i == CHSD_MODE_DISK_INTERFACE) ? link.status_pin : 1'b1;
            peer_active_n_o <= (mode_i == CHSD_MODE_DISK_INTERFACE) ? link.aux_pin : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Master or slave strap
    // ------------------------------------------------------------
    logic strap_done_r;

    // Sampled once, in the first cycle after reset is released.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            strap_done_r <= 1'b0;
            is_master_o <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            is_master_o <= (mode_i == CHSD_MODE_DISK_INTERFACE) & ~link.cable_select_n;
        end
    end
endmodule : chsd_card_end

// [verilog/chsd_host_end.sv]
/*
  Host socket end: AXI4-Lite registers drive pin accesses onto the link.
  Assumes an AXI4-Lite master on clk_sys_i and the card end on the link.
*/
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module chsd_host_end #(
    parameter int STROBE_CYCLES = chsd_pkg::STROBE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    chsd_link_if.host link,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq_o
);
    import chsd_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire;
    logic [31:0] ctrl_r;
    logic [IRQ_W-1:0] irq_st_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_set;
    logic busy_r;
    logic [CNT_W-1:0] cnt_r;
    chsd_mode_t mode;

    assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign mode = chsd_mode_t'(ctrl_r[CTRL_MODE_LSB +: 3]);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r == REG_CTRL || aw_addr_r == REG_ACCESS || aw_addr_r == REG_STATUS ||
                                aw_addr_r == REG_IRQ_STATUS || aw_addr_r == REG_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= ctrl_r;
                REG_STATUS: s_axi_rdata <= {29'h0, link.aux_pin, link.status_pin, busy_r};
                REG_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_st_r};
                REG_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_r};
                REG_ACCESS: s_axi_rdata <= '0;
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control, interrupt status and mask
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RST;
            irq_mask_r <= '0;
            irq_st_r <= '0;
            irq_o <= 1'b0;
        end else begin
            if (wr_fire && aw_addr_r == REG_CTRL) begin
                ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_003F;
            end
            if (wr_fire && aw_addr_r == REG_IRQ_MASK && w_strb_r[0]) begin
                irq_mask_r <= w_data_r[IRQ_W-1:0];
            end
            // A new event in the clearing cycle stays set.
            if (wr_fire && aw_addr_r == REG_IRQ_STATUS && w_strb_r[0]) begin
                irq_st_r <= (irq_st_r & ~w_data_r[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_st_r <= irq_st_r | irq_set;
            end
            irq_o <= |(irq_st_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Pin access sequencer
    // ------------------------------------------------------------
    logic status_prev_r;
    logic done_pulse;
    logic start;

    assign start = wr_fire & (aw_addr_r == REG_ACCESS) & ~busy_r;
    assign done_pulse = busy_r & (cnt_r == CNT_W'(1));
    assign irq_set[IRQ_DONE_BIT] = done_pulse;
    assign irq_set[IRQ_ALERT_BIT] = (mode == CHSD_MODE_IO) & status_prev_r & ~link.status_pin;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            status_prev_r <= 1'b1;
        end else begin
            status_prev_r <= link.status_pin;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            cnt_r <= '0;
            link.addr <= '0;
            link.attr_select_n <= 1'b1;
            link.card_enable_even_n <= 1'b1;
            link.card_enable_odd_n <= 1'b1;
            link.mem_rd_n <= 1'b1;
            link.mem_wr_n <= 1'b1;
            link.io_rd_n <= 1'b1;
            link.io_wr_n <= 1'b1;
        end else if (start) begin
            busy_r <= 1'b1;
            cnt_r <= CNT_W'(STROBE_CYCLES);
            if (mode == CHSD_MODE_DISK_INTERFACE) begin
                link.addr <= {8'h00, w_data_r[ACC_ADDR_LSB +: IDE_ADDR_W]};
            end else begin
                link.addr <= w_data_r[ACC_ADDR_LSB +: ADDR_W];
            end
            link.attr_select_n <= ~w_data_r[ACC_ATTR_BIT];
            link.card_enable_even_n <= ~w_data_r[ACC_EVEN_BIT];
            link.card_enable_odd_n <= ~w_data_r[ACC_ODD_BIT];
            link.mem_rd_n <= w_data_r[ACC_IO_BIT] | w_data_r[ACC_WRITE_BIT];
            link.mem_wr_n <= w_data_r[ACC_IO_BIT] | ~w_data_r[ACC_WRITE_BIT];
            link.io_rd_n <= ~w_data_r[ACC_IO_BIT] | w_data_r[ACC_WRITE_BIT];
            link.io_wr_n <= ~w_data_r[ACC_IO_BIT] | ~w_data_r[ACC_WRITE_BIT];
        end else if (busy_r) begin
            cnt_r <= cnt_r - CNT_W'(1);
            if (done_pulse) begin
                busy_r <= 1'b0;
                link.card_enable_even_n <= 1'b1;
                link.card_enable_odd_n <= 1'b1;
                link.mem_rd_n <= 1'b1;
                link.mem_wr_n <= 1'b1;
                link.io_rd_n <= 1'b1;
                link.io_wr_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            link.cable_select_n <= 1'b1;
            link.host_status_o <= 1'b1;
            link.host_status_oe <= 1'b0;
            link.host_aux_o <= 1'b1;
            link.host_aux_oe <= 1'b0;
        end else begin
            link.cable_select_n <= ~ctrl_r[CTRL_CABLE_GND_BIT];
            link.host_status_o <= 1'b0;
            link.host_status_oe <= (mode == CHSD_MODE_DISK_INTERFACE) & ctrl_r[CTRL_PEER_DIAG_BIT];
            link.host_aux_o <= 1'b0;
            link.host_aux_oe <= (mode == CHSD_MODE_DISK_INTERFACE) & ctrl_r[CTRL_PEER_ACTIVE_BIT];
        end
    end
endmodule : chsd_host_end

// [verilog/chsd_link_if.sv]
/*
  Pin-level link between host socket end and card end.
  Shared pins are open-drain with a pull-up, resolved here from both enables.
*/
`timescale 1ns/1ps
interface chsd_link_if;
    logic [10:0] addr;
    logic attr_select_n;
    logic card_enable_even_n;
    logic card_enable_odd_n;
    logic mem_rd_n;
    logic mem_wr_n;
    logic io_rd_n;
    logic io_wr_n;
    logic cable_select_n;
    logic dev_status_o;
    logic dev_status_oe;
    logic dev_aux_o;
    logic dev_aux_oe;
    logic host_status_o;
    logic host_status_oe;
    logic host_aux_o;
    logic host_aux_oe;
    logic status_pin;
    logic aux_pin;

    // A driven low wins; an undriven pin floats high on its pull-up.
    assign status_pin = ~((dev_status_oe & ~dev_status_o) | (host_status_oe & ~host_status_o));
    assign aux_pin = ~((dev_aux_oe & ~dev_aux_o) | (host_aux_oe & ~host_aux_o));

    modport device (
        input addr, attr_select_n, card_enable_even_n, card_enable_odd_n,
        input mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, cable_select_n, status_pin, aux_pin,
        output dev_status_o, dev_status_oe, dev_aux_o, dev_aux_oe
    );
    modport host (
        output addr, attr_select_n, card_enable_even_n, card_enable_odd_n,
        output mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, cable_select_n,
        output host_status_o, host_status_oe, host_aux_o, host_aux_oe,
        input status_pin, aux_pin
    );
endinterface : chsd_link_if

// [verilog/chsd_pkg.sv]
/*
  Shared constants, types and decode function of the card select decode block.
  Assumes a single 250 MHz clock on both ends.
*/
package chsd_pkg;
    localparam int ADDR_W = 11;
    localparam int IDE_ADDR_W = 3;
    localparam int CFG_ADDR_BIT = 9;
    localparam int CLK_NS = 4;
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;

    typedef enum logic [2:0] {
        CHSD_MODE_MEM = 3'b001,
        CHSD_MODE_IO = 3'b010,
        CHSD_MODE_DISK_INTERFACE = 3'b100
    } chsd_mode_t;

    typedef enum logic [6:0] {
        CHSD_RGN_NONE = 7'b0000001,
        CHSD_RGN_IO_PORT = 7'b0000010,
        CHSD_RGN_MEM_REG = 7'b0000100,
        CHSD_RGN_CIS = 7'b0001000,
        CHSD_RGN_CONFIG = 7'b0010000,
        CHSD_RGN_TASKFILE = 7'b0100000,
        CHSD_RGN_CTRL_BLOCK = 7'b1000000
    } chsd_region_t;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACCESS = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CABLE_GND_BIT = 3;
    localparam int CTRL_PEER_DIAG_BIT = 4;
    localparam int CTRL_PEER_ACTIVE_BIT = 5;
    localparam int ACC_ADDR_LSB = 0;
    localparam int ACC_ATTR_BIT = 11;
    localparam int ACC_EVEN_BIT = 12;
    localparam int ACC_ODD_BIT = 13;
    localparam int ACC_IO_BIT = 14;
    localparam int ACC_WRITE_BIT = 15;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_STATUS_PIN_BIT = 1;
    localparam int ST_AUX_PIN_BIT = 2;
    localparam int IRQ_W = 2;
    localparam int IRQ_ALERT_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Picks the register set that an access on the pins lands in.
    function automatic chsd_region_t chsd_decode(input chsd_mode_t mode, input logic [ADDR_W-1:0] addr,
                                                 input logic attr_n, input logic even_n, input logic odd_n,
                                                 input logic mem_acc, input logic io_acc);
        chsd_region_t r;
        logic sel;
        logic [0:0] cfg;
        r = CHSD_RGN_NONE;
        sel = ~(even_n & odd_n);
        cfg = addr[CFG_ADDR_BIT];
        unique case (mode)
            CHSD_MODE_MEM, CHSD_MODE_IO: begin
                if (sel && io_acc && !attr_n && mode == CHSD_MODE_IO) begin
                    r = CHSD_RGN_IO_PORT;
                end else if (sel && mem_acc) begin
                    r = attr_n ? CHSD_RGN_MEM_REG : (cfg[0] ? CHSD_RGN_CONFIG : CHSD_RGN_CIS);
                end
            end
            CHSD_MODE_DISK_INTERFACE: begin
                if (io_acc && !even_n) begin
                    r = CHSD_RGN_TASKFILE;
                end else if (io_acc && !odd_n) begin
                    r = CHSD_RGN_CTRL_BLOCK;
                end
            end
            default: r = CHSD_RGN_NONE;
        endcase
        return r;
    endfunction : chsd_decode
endpackage : chsd_pkg
